// ===== sim/fwtap_source.sv
/*
 * Upstream writer and test controller model for the FIFO write port.
 * Assumes its tasks are called one at a time, just after a core edge.
 */
`timescale 1ns/10ps
`default_nettype none
module fwtap_source
	import fwtap_pkg::*;
(
	// Write port pins
	output logic write_clock,
	output logic write_enable_n,
	output logic write_chip_select_n,
	output logic write_async_mode,
	output logic offset_load_n,
	output logic master_reset_n,
	output logic [DATA_W-1:0] write_data,
	// Test port pins
	output logic test_clock,
	output logic test_mode_select,
	output logic test_data_in,
	output logic test_reset_n
);
	initial begin
		write_clock = 1'b0;
		write_enable_n = 1'b1;
		write_chip_select_n = 1'b1;
		write_async_mode = 1'b0;
		offset_load_n = 1'b1;
		master_reset_n = 1'b1;
		write_data = '0;
		test_clock = 1'b0;
		test_mode_select = 1'b1;
		test_data_in = 1'b1;
		// No reset at power-up, so the port starts unreset
		test_reset_n = 1'b1;
	end

	// One 240 ns word with the strobe high for 80 ns; enable is driven as passed in, in either mode
	task automatic word(input logic we_n, cs_n, ld_n,
		input logic [DATA_W-1:0] d);
		write_enable_n = we_n;
		write_chip_select_n = cs_n;
		offset_load_n = ld_n;
		write_data = d;
		#80 write_clock = 1'b1;
		#80 write_clock = 1'b0;
		// Released bus must not keep showing the word
		write_data = ~d;
		#80;
	endtask

	// Mode only changes while master reset is held
	task automatic mreset(input logic asy);
		master_reset_n = 1'b0;
		#100 write_async_mode = asy;
		#100 master_reset_n = 1'b1;
		#100;
	endtask

	// Test clock runs only inside this task, otherwise stands low
	task automatic tck(input logic tms, tdi);
		test_mode_select = tms;
		test_data_in = tdi;
		#80 test_clock = 1'b1;
		#80 test_clock = 1'b0;
		#120;
	endtask

	task automatic trst();
		test_reset_n = 1'b0;
		#200 test_reset_n = 1'b1;
	endtask

	// Test reset wired to master reset: both move together
	task automatic tied_reset();
		master_reset_n = 1'b0;
		test_reset_n = 1'b0;
		#200 master_reset_n = 1'b1;
		test_reset_n = 1'b1;
		#100;
	endtask

	// Boundary scan unused: test reset parked low
	task automatic park_trst(input logic v);
		test_reset_n = v;
	endtask
endmodule
`default_nettype wire

// ===== sim/testbench.sv
/*
 * Self-checking bench for the FIFO write port and test port gating.
 * Assumes the source model drives every pin; clk_en is held high.
 */
`timescale 1ns/10ps
`default_nettype none
module testbench
	import fwtap_pkg::*;
;
	logic core_clk, reset_n, read_advance;
	wire logic write_clock, write_enable_n, write_chip_select_n;
	wire logic write_async_mode, offset_load_n, master_reset_n;
	wire logic [DATA_W-1:0] write_data;
	wire logic test_clock, test_mode_select, test_data_in, test_reset_n;
	logic [DATA_W-1:0] read_data;
	logic [ADDR_W:0] write_pointer;
	logic fifo_full, data_out_enable, test_data_out, test_data_out_oe;
	logic [OFFSET_W-1:0] offset_value;
	int n_mismatch, samples_checked, cycles;
	// Row: async, enable_n, chip_select_n, offset_load_n, pointer step
	logic [4:0] rows [7] = '{5'b00011, 5'b01010, 5'b00110, 5'b01110,
		5'b00000, 5'b10011, 5'b10110};

	fwtap_source u_src (.write_clock(write_clock),
		.write_enable_n(write_enable_n),
		.write_chip_select_n(write_chip_select_n),
		.write_async_mode(write_async_mode), .offset_load_n(offset_load_n),
		.master_reset_n(master_reset_n), .write_data(write_data),
		.test_clock(test_clock), .test_mode_select(test_mode_select),
		.test_data_in(test_data_in), .test_reset_n(test_reset_n));

	fwtap_write_port u_fwtap_write_port (.core_clk(core_clk),
		.reset_n(reset_n), .clk_en(1'b1), .write_clock(write_clock),
		.write_enable_n(write_enable_n),
		.write_chip_select_n(write_chip_select_n),
		.write_async_mode(write_async_mode), .offset_load_n(offset_load_n),
		.master_reset_n(master_reset_n), .write_data(write_data),
		.read_advance(read_advance), .read_data(read_data),
		.write_pointer(write_pointer), .fifo_full(fifo_full),
		.offset_value(offset_value), .data_out_enable(data_out_enable),
		.test_clock(test_clock), .test_mode_select(test_mode_select),
		.test_data_in(test_data_in), .test_reset_n(test_reset_n),
		.test_data_out(test_data_out), .test_data_out_oe(test_data_out_oe));

	task automatic check(input logic [31:0] got, exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask

	task automatic end_of_test();
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	// Full-depth fill dominates the run, about 25k cycles
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 40000) begin
			n_mismatch++;
			end_of_test();
		end
	end

	initial begin
		logic mode;
		logic [4:0] r;
		logic [DATA_W-1:0] d;
		logic [ADDR_W:0] exp_ptr;
		reset_n = 1'b0;
		read_advance = 1'b0;
		mode = 1'b0;
		exp_ptr = '0;
		repeat (2) @(posedge core_clk);
		#2 reset_n = 1'b1;
		for (int i = 0; i < 7; i++) begin
			r = rows[i];
			d = 18'h2A5C3 ^ DATA_W'(i);
			@(posedge core_clk);
			#2;
			if (r[4] !== mode) begin
				mode = r[4];
				u_src.mreset(mode);
				exp_ptr = '0;
			end
			u_src.word(r[3], r[2], r[1], d);
			if (r[0]) exp_ptr++;
			check(write_pointer, exp_ptr);
			if (!r[1]) check(offset_value, d[10:0]);
		end
		check(data_out_enable, 1'b0);
		repeat (5) u_src.tck(1'b1, 1'b1);
		check(data_out_enable, 1'b1);
		u_src.tck(1'b0, 1'b0);
		u_src.tck(1'b1, 1'b0);
		u_src.tck(1'b1, 1'b0);
		u_src.tck(1'b0, 1'b0);
		u_src.tck(1'b0, 1'b1);
		check(test_data_out_oe, 1'b1);
		check(test_data_out, 1'b1);
		u_src.tck(1'b0, 1'b1);
		check(test_data_out, 1'b0);
		u_src.tck(1'b1, 1'b1);
		check(test_data_out_oe, 1'b0);
		// Two passes: test reset alone, then test reset tied to master reset
		for (int k = 0; k < 2; k++) begin
			@(posedge core_clk);
			#2 reset_n = 1'b0;
			repeat (2) @(posedge core_clk);
			#2 reset_n = 1'b1;
			// No false test reset out of the synchronisers
			repeat (4) @(posedge core_clk);
			#2 check(data_out_enable, 1'b0);
			if (k == 0) u_src.trst();
			else u_src.tied_reset();
			repeat (8) @(posedge core_clk);
			check(data_out_enable, 1'b1);
		end
		#2 u_src.mreset(1'b0);
		u_src.park_trst(1'b0);
		for (int n = 0; n < 2048; n++) begin
			u_src.word(1'b0, 1'b0, 1'b1, 18'h15555 ^ DATA_W'(n));
		end
		check(data_out_enable, 1'b1);
		check(write_pointer, 12'h800);
		check(fifo_full, 1'b1);
		u_src.word(1'b0, 1'b0, 1'b1, 18'h3FFFF);
		check(write_pointer, 12'h800);
		check(read_data, 18'h15555);
		@(posedge core_clk);
		#2 read_advance = 1'b1;
		@(posedge core_clk);
		#2 read_advance = 1'b0;
		repeat (3) @(posedge core_clk);
		check(read_data, 18'h15554);
		check(fifo_full, 1'b0);
		end_of_test();
	end
endmodule
`default_nettype wire

// ===== verilog/fwtap_mem.sv
/*
 * Simple dual-port word store for the FIFO write side.
 * Assumes write and read on the same clock; read data is registered.
 */
`timescale 1ns/10ps
`default_nettype none
module fwtap_mem #(
	parameter int DW = 18,
	parameter int AW = 11
) (
	// Clock and control
	input wire logic clk,
	input wire logic reset_n,
	input wire logic ce,
	// Write side
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [DW-1:0] wdata,
	// Read side
	input wire logic [AW-1:0] raddr,
	output logic [DW-1:0] rdata
);
	logic [DW-1:0] store [0:(1<<AW)-1];

	// No reset on the array so it maps to block RAM
	always_ff @(posedge clk) begin
		if (ce && we) begin
			store[waddr] <= wdata;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rdata <= '0;
		end else if (ce) begin
			rdata <= store[raddr];
		end
	end
endmodule
`default_nettype wire

// ===== verilog/fwtap_pkg.sv
/*
 * Shared constants and types for the FIFO write port and its test port
 * reset gating. Assumes a single core clock domain; all pins sampled.
 */
`default_nettype none
package fwtap_pkg;
	// Write port geometry
	localparam int DATA_W = 18;
	localparam int ADDR_W = 11;
	localparam int OFFSET_W = 11;
	localparam logic [OFFSET_W-1:0] OFFSET_RST = 11'h000;
	// Input synchroniser depth
	localparam int SYNC_STAGES = 2;
	// Idle levels of the ten control pins, test clock down to async mode
	localparam logic [9:0] PIN_IDLE = 10'h1DE;
	// Test clock edges with mode select high that force test reset
	localparam int TMS_RESET_EDGES = 5;
	localparam logic [2:0] TMS_RESET_CNT = 3'h5;
	// Instruction register
	localparam int IR_W = 4;
	localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
	localparam logic [IR_W-1:0] IR_RST = 4'hF;

	typedef enum logic [3:0] {
		TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR,
		TAP_PA_DR, TAP_EX2_DR, TAP_UP_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR,
		TAP_EX1_IR, TAP_PA_IR, TAP_EX2_IR, TAP_UP_IR
	} fwtap_state_t;
endpackage
`default_nettype wire

// ===== verilog/fwtap_write_port.sv
/*
 * FIFO write port with test access port controller and output gating.
 * Assumes all pins arrive asynchronously to core_clk and are much slower
 * than it; the read side sits on core_clk.
 */
// What this block does
// R1: Mode select steers test controller each test clock.
// R2: Test reset forces controller reset, no test clock.
// R3: Controller never self-resets at power-up.
// R4: Five mode-select-high test clocks also reset controller.
// R5: Outputs stay high-impedance until controller was reset.
// R6: System may tie test reset to master reset.
// R7: Unused test port: system holds test reset low.
// R8: Gated write clock loads memory or offset register.
// R9: Synchronous mode: enabled write clock edge stores word.
// R10: Asynchronous mode: writer holds write enable low.
// R11: Asynchronous mode: write strobe rising edge stores word.
// R12: Chip select acts as second write enable.
// R13: Level select stays static after master reset.
// R14: Sample on rising test clock, drive output falling.
// R15: Test output driven only in shift states.
// R16: Enable and chip select active low, both required in synchronous mode; asynchronous mode needs only chip select.
// R17: Writes while full are ignored.
`timescale 1ns/10ps
`default_nettype none
module fwtap_write_port
	import fwtap_pkg::*;
#(
	parameter int DW = DATA_W,
	parameter int AW = ADDR_W
) (
	// Clock, reset, enable
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic clk_en,
	// Write port pins
	input wire logic write_clock,
	input wire logic write_enable_n,
	input wire logic write_chip_select_n,
	input wire logic write_async_mode,
	input wire logic offset_load_n,
	input wire logic master_reset_n,
	input wire logic [DW-1:0] write_data,
	// Read side, same clock
	input wire logic read_advance,
	output logic [DW-1:0] read_data,
	output logic [AW:0] write_pointer,
	output logic fifo_full,
	output logic [OFFSET_W-1:0] offset_value,
	output logic data_out_enable,
	// Test port pins
	input wire logic test_clock,
	input wire logic test_mode_select,
	input wire logic test_data_in,
	input wire logic test_reset_n,
	output logic test_data_out,
	output logic test_data_out_oe
);
	localparam int NP = 10 + DW;
	localparam logic [AW:0] DEPTH = {1'h1, {AW{1'h0}}};
	// Reset to idle pin levels: zeros would look like a test reset
	localparam logic [NP-1:0] SYNC_IDLE = {PIN_IDLE, {DW{1'h0}}};

	// Two-stage synchronisers; only s2 is read by logic
	logic [NP-1:0] s1, s2;
	logic [1:0] edge_q;
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			s1 <= SYNC_IDLE;
			s2 <= SYNC_IDLE;
			edge_q <= 2'h0;
		end else if (clk_en) begin
			s1 <= {test_clock, test_mode_select, test_data_in, test_reset_n,
				write_clock, write_enable_n, write_chip_select_n,
				offset_load_n, master_reset_n, write_async_mode,
				write_data};
			s2 <= s1;
			edge_q <= {s2[NP-1], s2[NP-5]};
		end
	end

	wire tck_s = s2[NP-1];
	wire tms_s = s2[NP-2];
	wire tdi_s = s2[NP-3];
	wire trst_s = s2[NP-4];
	wire wclk_s = s2[NP-5];
	wire wen_s = s2[NP-6];
	wire chip_sel_s = s2[NP-7];
	wire ld_s = s2[NP-8];
	wire master_rst_s = s2[NP-9];
	wire async_s = s2[NP-10];
	wire [DW-1:0] wdata_s = s2[DW-1:0];
	wire tck_rise = tck_s && !edge_q[1];
	wire tck_fall = !tck_s && edge_q[1];
	wire wclk_rise = wclk_s && !edge_q[0];

	// Write qualification
	logic [AW:0] rptr;
	wire [AW:0] fill = write_pointer - rptr;
	wire full_now = (fill == DEPTH);
	wire empty_now = (fill == '0);
	// Async mode ignores enable; writer ties it low anyway [R10]
	wire en_ok = async_s || !wen_s; // [R11] [R16]
	wire gated = wclk_rise && en_ok && !chip_sel_s; // [R8] [R12] [R16]
	wire load_off = gated && !ld_s; // [R8]
	wire mem_we = gated && ld_s && !full_now; // [R9] [R17]
	wire rd_go = read_advance && !empty_now;

	fwtap_mem #(.DW(DW), .AW(AW)) u_mem (
		.clk(core_clk),
		.reset_n(reset_n),
		.ce(clk_en),
		.we(mem_we),
		.waddr(write_pointer[AW-1:0]),
		.wdata(wdata_s),
		.raddr(rptr[AW-1:0]),
		.rdata(read_data)
	);

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			write_pointer <= '0;
			rptr <= '0;
			offset_value <= OFFSET_RST;
			fifo_full <= 1'h0;
		end else if (clk_en) begin
			if (!master_rst_s) begin
				write_pointer <= '0;
				rptr <= '0;
				offset_value <= OFFSET_RST;
				fifo_full <= 1'h0;
			end else begin
				if (mem_we) begin
					write_pointer <= write_pointer + 1'h1; // [R9] [R11]
				end
				if (load_off) begin
					offset_value <= wdata_s[OFFSET_W-1:0]; // [R8]
				end
				if (rd_go) begin
					rptr <= rptr + 1'h1;
				end
				fifo_full <= (fill + {{AW{1'h0}}, mem_we}
					- {{AW{1'h0}}, rd_go}) == DEPTH;
			end
		end
	end

	// Test access port controller
	fwtap_state_t tap, next_tap;
	always_comb begin
		next_tap = tap;
		case (tap)
			TAP_RESET: next_tap = tms_s ? TAP_RESET : TAP_IDLE;
			TAP_IDLE: next_tap = tms_s ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_DR: next_tap = tms_s ? TAP_SEL_IR : TAP_CAP_DR;
			TAP_CAP_DR: next_tap = tms_s ? TAP_EX1_DR : TAP_SH_DR;
			TAP_SH_DR: next_tap = tms_s ? TAP_EX1_DR : TAP_SH_DR;
			TAP_EX1_DR: next_tap = tms_s ? TAP_UP_DR : TAP_PA_DR;
			TAP_PA_DR: next_tap = tms_s ? TAP_EX2_DR : TAP_PA_DR;
			TAP_EX2_DR: next_tap = tms_s ? TAP_UP_DR : TAP_SH_DR;
			TAP_UP_DR: next_tap = tms_s ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_IR: next_tap = tms_s ? TAP_RESET : TAP_CAP_IR;
			TAP_CAP_IR: next_tap = tms_s ? TAP_EX1_IR : TAP_SH_IR;
			TAP_SH_IR: next_tap = tms_s ? TAP_EX1_IR : TAP_SH_IR;
			TAP_EX1_IR: next_tap = tms_s ? TAP_UP_IR : TAP_PA_IR;
			TAP_PA_IR: next_tap = tms_s ? TAP_EX2_IR : TAP_PA_IR;
			TAP_EX2_IR: next_tap = tms_s ? TAP_UP_IR : TAP_SH_IR;
			TAP_UP_IR: next_tap = tms_s ? TAP_SEL_DR : TAP_IDLE;
			default: next_tap = TAP_RESET;
		endcase
	end

	wire in_shift = (tap == TAP_SH_DR) || (tap == TAP_SH_IR);
	logic tap_ok;
	logic bypass;
	logic [IR_W-1:0] ir_sh, ir;

	// Power-up lands in idle, not reset: a real reset must be seen
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			tap <= TAP_IDLE; // [R3]
			tap_ok <= 1'h0; // [R3]
			bypass <= 1'h0;
			ir_sh <= '0;
			ir <= IR_RST;
		end else if (clk_en) begin
			if (!trst_s) begin
				tap <= TAP_RESET; // [R2] [R7]
			end else if (tck_rise) begin
				tap <= next_tap; // [R1] [R4] [R14]
				if (tap == TAP_CAP_DR) begin
					bypass <= 1'h0;
				end else if (tap == TAP_SH_DR) begin
					bypass <= tdi_s; // [R14]
				end
				if (tap == TAP_CAP_IR) begin
					ir_sh <= IR_CAPTURE;
				end else if (tap == TAP_SH_IR) begin
					ir_sh <= {tdi_s, ir_sh[IR_W-1:1]}; // [R14]
				end else if (tap == TAP_UP_IR) begin
					ir <= ir_sh;
				end
			end
			if (tap == TAP_RESET) begin
				tap_ok <= 1'h1;
				ir <= IR_RST;
			end
		end
	end

	// Test output moves only on falling test clock
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			test_data_out <= 1'h0;
			test_data_out_oe <= 1'h0;
			data_out_enable <= 1'h0;
		end else if (clk_en) begin
			if (tck_fall) begin
				test_data_out <= (tap == TAP_SH_IR) ? ir_sh[0] : bypass;
				test_data_out_oe <= in_shift; // [R14] [R15]
			end
			data_out_enable <= tap_ok; // [R5] [R6]
		end
	end

	// Checking helpers
	logic [2:0] tms_run;
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			tms_run <= 3'h0;
		end else if (clk_en && tck_rise) begin
			if (!tms_s) begin
				tms_run <= 3'h0;
			end else if (tms_run != TMS_RESET_CNT) begin
				tms_run <= tms_run + 3'h1;
			end
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	chk_tap_step: assert property ( // [R1]
		(clk_en && trst_s && tck_rise) |=> tap == $past(next_tap))
		else $error("test controller skipped a step");
	chk_trst_forces: assert property ( // [R2]
		(clk_en && !trst_s) |=> tap == TAP_RESET)
		else $error("test reset did not reset controller");
	chk_no_self_reset: assert property ( // [R3]
		$rose(tap_ok) |-> $past(tap) == TAP_RESET)
		else $error("controller ready without a reset");
	chk_tms_five_reset: assert property ( // [R4]
		(tms_run == TMS_RESET_CNT) |-> tap == TAP_RESET)
		else $error("five high mode selects did not reset");
	chk_outputs_hiz: assert property ( // [R5]
		data_out_enable |-> $past(tap_ok))
		else $error("outputs enabled before controller reset");
	chk_tdo_falling: assert property ( // [R14]
		(!tck_fall || !clk_en) |=> $stable(test_data_out))
		else $error("test output moved off falling edge");
	chk_tdo_oe_shift: assert property ( // [R15]
		(clk_en && tck_fall) |=> test_data_out_oe == $past(in_shift))
		else $error("test output enable outside shift");
	chk_write_qual: assert property ( // [R12]
		mem_we |-> (!chip_sel_s && (async_s || !wen_s)))
		else $error("write stored without both enables");
	chk_write_adv: assert property ( // [R9]
		(clk_en && mem_we && master_rst_s) |=> write_pointer
			== $past(write_pointer) + 1'h1)
		else $error("write did not advance pointer");
	chk_async_strobe: assert property ( // [R11]
		(async_s && wclk_rise && !chip_sel_s && ld_s && !full_now)
			|-> mem_we)
		else $error("async strobe edge not stored");
	chk_full_ignore: assert property ( // [R17]
		(clk_en && full_now && !rd_go && master_rst_s)
			|=> $stable(write_pointer))
		else $error("write while full moved pointer");
	chk_offset_load: assert property ( // [R8]
		(clk_en && load_off && master_rst_s) |=> (offset_value
			== $past(wdata_s[OFFSET_W-1:0])) && $stable(write_pointer))
		else $error("offset load went wrong");
endmodule
`default_nettype wire
